//--- src/comm_timer.sv
// Dual commutation timer: one prescaled counter and compare per motor.
// Assumes an APB master on pclk and PWM generators on the same clock.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps

// What this block does
// - Channel 0 drives its compare output flag as the forced update into the first PWM generator.
// - Each counter advances once per prescaler tick of 128 motor-domain clocks.
// - The compare register sets the counter value at which the next commutation happens.
// - A counter match with the compare value sets the compare output flag, which is the force.
// - An independent second channel serves the second motor and drives the second PWM force.
// - Every compare event raises an interrupt so software can preload the next sector.
module comm_timer #(
  parameter int CNT_W = 16,
  parameter int PRESCALE = comm_timer_pkg::PRESCALE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM force and compare interrupts
  output logic [1:0] pwm_force,
  output logic [1:0] comm_irq
);
  localparam int CH = comm_timer_pkg::CHANNELS;
  localparam int PS_W = $clog2(PRESCALE);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  // The read mux zero-extends into one 32-bit word, so wider counters cannot be served.
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
    $error("comm_timer: counter width out of range");
  end
  // A divide by one would tick every cycle and leave the prescaler with no bits.
  if (PRESCALE < 2) begin : g_bad_prescale
    $error("comm_timer: prescaler below two");
  end
  // The register map and the port widths carry exactly two channels.
  if (CH != 2) begin : g_bad_channels
    $error("comm_timer: channel count must be two");
  end

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  comm_timer_pkg::apb_req_s req;
  logic wr_en;
  logic hit;
  logic [CH-1:0] en_r;
  logic [CH-1:0] flag_r;
  logic [CH-1:0] flag_clr;
  logic [CH-1:0] match;
  logic [CNT_W-1:0] cmp_r [CH];
  logic [CNT_W-1:0] cnt_r [CH];
  logic [PS_W-1:0] ps_r;
  logic tick;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign pready = 1'b1;
  assign wr_en = psel && penable && req.write;
  always_comb begin
    unique case (req.addr)
      comm_timer_pkg::CTRL_OFF, comm_timer_pkg::STATUS_OFF, comm_timer_pkg::CMP0_OFF,
      comm_timer_pkg::CMP1_OFF, comm_timer_pkg::CNT0_OFF, comm_timer_pkg::CNT1_OFF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= comm_timer_pkg::CTRL_RST;
    end else if (wr_en && req.addr == comm_timer_pkg::CTRL_OFF) begin
      en_r <= req.wdata[comm_timer_pkg::CTRL_EN1_BIT:comm_timer_pkg::CTRL_EN0_BIT];
    end
  end

  // Writing a one to a status bit clears it; a match in the same cycle wins.
  // Losing a set to a racing clear would silently drop one commutation interrupt.
  assign flag_clr = (wr_en && req.addr == comm_timer_pkg::STATUS_OFF) ? req.wdata[1:0] : 2'h0;

  // Read data is loaded in the setup cycle so that it already stands in the access phase.
  // This keeps the slave at zero wait states at the cost of one register per bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !req.write) begin
      unique case (req.addr)
        comm_timer_pkg::CTRL_OFF: prdata <= {30'h0, en_r};
        comm_timer_pkg::STATUS_OFF: prdata <= {30'h0, flag_r};
        comm_timer_pkg::CMP0_OFF: prdata <= 32'(cmp_r[0]);
        comm_timer_pkg::CMP1_OFF: prdata <= 32'(cmp_r[1]);
        comm_timer_pkg::CNT0_OFF: prdata <= 32'(cnt_r[0]);
        comm_timer_pkg::CNT1_OFF: prdata <= 32'(cnt_r[1]);
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  // One prescaler is shared, so both channels tick on the same edge.
  assign tick = (ps_r == PS_W'(PRESCALE - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= '0;
    end else begin
      ps_r <= tick ? '0 : ps_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic clr_cnt;
    logic match_d_r;
    localparam logic [11:0] CMP_ADDR = (i == 0) ? comm_timer_pkg::CMP0_OFF :
                                                  comm_timer_pkg::CMP1_OFF;
    assign clr_cnt = wr_en && req.addr == comm_timer_pkg::CTRL_OFF &&
                     req.wdata[comm_timer_pkg::CTRL_CLR0_BIT + i];
    assign match[i] = en_r[i] && (cnt_r[i] == cmp_r[i]);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmp_r[i] <= CNT_W'(comm_timer_pkg::CMP_RST);
      end else if (wr_en && req.addr == CMP_ADDR) begin
        cmp_r[i] <= req.wdata[CNT_W-1:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r[i] <= '0;
      end else if (clr_cnt) begin
        cnt_r[i] <= '0;
      end else if (en_r[i] && tick) begin
        cnt_r[i] <= cnt_r[i] + 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        match_d_r <= 1'b0;
        pwm_force[i] <= 1'b0;
        flag_r[i] <= 1'b0;
      end else begin
        match_d_r <= match[i];
        pwm_force[i] <= match[i] && !match_d_r;
        flag_r[i] <= (match[i] && !match_d_r) || (flag_r[i] && !flag_clr[i]);
      end
    end

    AST_FORCE_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
      pwm_force[i] |=> !pwm_force[i]) else $error("force longer than one cycle");
    AST_MATCH_FORCES: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(match[i]) |=> pwm_force[i]) else $error("match without force");
    AST_FORCE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
      pwm_force[i] |-> $past(match[i]) && cnt_r[i] == cmp_r[i])
      else $error("force without match");
    AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
      pwm_force[i] |-> comm_irq[i]) else $error("irq missing on force");

    // --------------------------------------------------------------------
    // Channel checks
    // --------------------------------------------------------------------
    AST_CMP_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && req.addr == CMP_ADDR |=> cmp_r[i] == $past(req.wdata[CNT_W-1:0]))
      else $error("compare write lost");
    AST_CNT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      clr_cnt |=> cnt_r[i] == '0) else $error("counter not cleared");
    AST_CNT_ADVANCE: assert property (@(posedge pclk) disable iff (!presetn)
      en_r[i] && tick && !clr_cnt |=> cnt_r[i] == CNT_W'($past(cnt_r[i]) + 1'b1))
      else $error("counter missed a tick");
    AST_IDLE_NO_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
      !en_r[i] |=> !pwm_force[i]) else $error("force from a disabled channel");
    AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      comm_irq[i] && !flag_clr[i] |=> comm_irq[i]) else $error("interrupt dropped");
    AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      flag_clr[i] && !(match[i] && !match_d_r) |=> !comm_irq[i])
      else $error("interrupt not cleared");
    AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      match[i] && !match_d_r |=> comm_irq[i]) else $error("set lost to clear");
  end

  assign comm_irq = flag_r;

  AST_PRESCALE: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick [*8]) else $error("prescaler tick too frequent");
  AST_CNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    en_r[0] && !tick && !$past(tick) ##1 1'b1 |-> cnt_r[0] == $past(cnt_r[0]) || $past(wr_en))
    else $error("counter moved off tick");
  AST_CH1_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force[1] |-> en_r[1] || $past(en_r[1])) else $error("channel 1 force while off");
  AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    flag_r[0] && flag_clr[0] == 1'b0 |=> flag_r[0]) else $error("flag lost");

  // ----------------------------------------------------------------------
  // Shared checks and a channel 1 cause check
  // ----------------------------------------------------------------------
  AST_PRESCALE_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> ps_r == '0) else $error("prescaler did not wrap");
  AST_CH1_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force[1] |-> $past(match[1])) else $error("channel 1 force without its match");
  AST_EN_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && req.addr == comm_timer_pkg::CTRL_OFF |=> en_r == $past(req.wdata[1:0]))
    else $error("enable write lost");
endmodule

//--- src/comm_timer_pkg.sv
// Package for the dual commutation timer: register map, layouts, reset values.
// Assumes a 32-bit APB slave on the motor-domain clock.
package comm_timer_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] CMP0_OFF = 12'h008;
  localparam logic [11:0] CMP1_OFF = 12'h00c;
  localparam logic [11:0] CNT0_OFF = 12'h010;
  localparam logic [11:0] CNT1_OFF = 12'h014;
  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_EN0_BIT = 0;
  localparam int CTRL_EN1_BIT = 1;
  localparam int CTRL_CLR0_BIT = 8;
  localparam int CTRL_CLR1_BIT = 9;
  localparam logic [15:0] CMP_RST = 16'hffff;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PRESCALE = 128;
  localparam int SRC_CLK_HZ = 120000000;
  localparam int TICK_HZ = SRC_CLK_HZ / PRESCALE;
  localparam int CHANNELS = 2;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_s;
endpackage

//--- test/pwm_gen_model.sv
// PWM generator stand-in: a pending sector setup and the applied one.
// Assumes the force input is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module pwm_gen_model (
  // Clock, reset and force
  input wire logic pclk,
  input wire logic presetn,
  input wire logic force_in,
  // Pending and applied setup
  input wire logic [7:0] pend,
  output logic [7:0] active
);
  // Pending values never leak through early, so a late force shows up as stale outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 8'h00;
    end else if (force_in) begin
      active <= pend;
    end
  end
endmodule

//--- test/tb_top.sv
// Testbench for the dual commutation timer: APB tasks and two PWM stand-ins.
// Assumes zero-wait APB and one shared 100 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pwm_force;
  logic [1:0] comm_irq;
  logic [7:0] pend0 = 8'h00;
  logic [7:0] pend1 = 8'h00;
  logic [7:0] act0;
  logic [7:0] act1;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int nf[2] = '{0, 0};
  int tf[2] = '{0, 0};
  always #5 pclk = ~pclk;
  comm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_force(pwm_force), .comm_irq(comm_irq));
  pwm_gen_model pwm0_u (.pclk(pclk), .presetn(presetn), .force_in(pwm_force[0]),
    .pend(pend0), .active(act0));
  pwm_gen_model pwm1_u (.pclk(pclk), .presetn(presetn), .force_in(pwm_force[1]),
    .pend(pend1), .active(act1));
  // Pulse counts catch both a stretched pulse and a repeated one.
  always @(posedge pclk) begin
    cyc++;
    for (int i = 0; i < 2; i++) if (pwm_force[i] === 1'b1) begin
      nf[i]++;
      tf[i] = cyc;
    end
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, comm_timer_pkg::CMP0_OFF, 32'h0);
    chk("cmp0 reset", 32'h0000ffff, rd);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    pend0 <= 8'h15;
    pend1 <= 8'h2a;
    apb(1'b1, comm_timer_pkg::CMP0_OFF, 32'h2);
    apb(1'b1, comm_timer_pkg::CMP1_OFF, 32'h3);
    apb(1'b1, comm_timer_pkg::CTRL_OFF, 32'h303);
    wait (nf[0] != 0);
    #1;
    chk("pwm0 active", 32'h15, {24'h0, act0});
    chk("pwm1 held", 32'h0, {24'h0, act1});
    chk("irq ch0", 32'h1, {30'h0, comm_irq});
    apb(1'b0, comm_timer_pkg::CNT0_OFF, 32'h0);
    chk("cnt0 at match", 32'h2, rd);
    wait (nf[1] != 0);
    #1;
    chk("pwm1 active", 32'h2a, {24'h0, act1});
    chk("tick gap", 32'd128, 32'(tf[1] - tf[0]));
    repeat (100) @(posedge pclk);
    chk("pulses ch0", 32'h1, 32'(nf[0]));
    chk("pulses ch1", 32'h1, 32'(nf[1]));
    chk("irq both", 32'h3, {30'h0, comm_irq});
    apb(1'b1, comm_timer_pkg::STATUS_OFF, 32'h3);
    apb(1'b0, comm_timer_pkg::STATUS_OFF, 32'h0);
    chk("status clear", 32'h0, rd);
    apb(1'b1, comm_timer_pkg::CMP0_OFF, 32'h5);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk("reset prdata", 32'h0, prdata);
    chk("reset force", 32'h0, {30'h0, pwm_force});
    chk("reset irq", 32'h0, {30'h0, comm_irq});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, comm_timer_pkg::CMP0_OFF, 32'h0);
    chk("cmp0 after reset", 32'h0000ffff, rd);
    apb(1'b0, comm_timer_pkg::CTRL_OFF, 32'h0);
    chk("ctrl after reset", 32'h0, rd);
    finish_test();
  end
endmodule
